// file: core/smr_pkg.sv
package smr_pkg;

    localparam int unsigned CLK_HZ = 20000000;

    // stretch after supply return or button release, figure in ms
    localparam int unsigned STRETCH_MS            = 150;
    localparam int unsigned STRETCH_CYCLES        = STRETCH_MS * (CLK_HZ / 1000);
    // least press width, figure in ns
    localparam int unsigned PRESS_MIN_NS          = 1000;
    localparam int unsigned PRESS_MIN_CYCLES      = (PRESS_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // longest detect delay, figure in ns
    localparam int unsigned FAIL_DETECT_MAX_NS    = 5000;
    localparam int unsigned FAIL_DETECT_MAX_CYCLES = FAIL_DETECT_MAX_NS * (CLK_HZ / 1000000) / 1000;

    localparam int unsigned SYNC_STAGES = 3;
    // cycles the synced pin lags our own release
    localparam int unsigned SETTLE_CYCLES = SYNC_STAGES + 1;

    // supply trip level variant
    typedef enum logic [1:0] {
        SMR_TRIP_5PCT  = 2'h0,
        SMR_TRIP_10PCT = 2'h1,
        SMR_TRIP_20PCT = 2'h2
    } smr_trip_t;

    typedef enum {
        SMR_ST_IDLE,
        SMR_ST_FAIL,
        SMR_ST_PRESS,
        SMR_ST_STRETCH
    } smr_state_t;

    // open-drain pin bundle
    typedef struct packed {
        logic out;
        logic oe;
    } smr_pin_drive_t;

endpackage

// file: core/smr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smr_sync
    import smr_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      change_o
);
    logic [SYNC_STAGES-1:0] stage_q;
    logic [SYNC_STAGES-1:0] stage_d;
    logic                   level_q;
    logic                   level_d;

    // stage 0 only feeds stage 1; stages 1 and 2 must agree
    always_comb begin
        stage_d = {stage_q[SYNC_STAGES-2:0], async_i};
        level_d = level_q;
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stage_q <= {SYNC_STAGES{RESET_VAL}};
            level_q <= RESET_VAL;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign level_o  = level_q;
    assign change_o = level_d != level_q;
endmodule
`default_nettype wire

// file: core/smr_supervisor.sv
// Notes on behaviour
// (RL1) Hold reset low while supply fail lasts.
// (RL2) After supply returns, stretch reset 150 ms.
// (RL3) Reset follows supply failure within 5 us.
// (RL4) Press counts only outside cycle, 1 us.
// (RL5) No drive during press; hold 150 ms after release.
// (RL6) Sense own pin as pushbutton input.
// (RL7) Trip level chosen by variant: 5/10/20%.
// (RL8) Own drive seen low never restarts stretch.
`timescale 1ns/1ps
`default_nettype none
module smr_supervisor
    import smr_pkg::*;
#(
    parameter int unsigned STRETCH_CNT = STRETCH_CYCLES,
    parameter int unsigned PRESS_CNT   = PRESS_MIN_CYCLES,
    parameter smr_trip_t   TRIP_LEVEL  = SMR_TRIP_10PCT
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       supply_fail_i,
    input  wire logic       rst_pin_i,
    output logic            rst_pin_o,
    output logic            rst_pin_oe_o,
    output logic            in_reset_o,
    output smr_trip_t       supply_trip_level_o
);
    localparam int unsigned CW = $clog2(STRETCH_CNT + 1);

    initial begin
        if (STRETCH_CNT <= SETTLE_CYCLES || PRESS_CNT < 1 || PRESS_CNT >= STRETCH_CNT) begin
            $error("smr_supervisor: bad count parameters");
        end
        if (FAIL_DETECT_MAX_CYCLES < SYNC_STAGES + 2) begin
            $error("smr_supervisor: detect path too slow");
        end
    end

    logic fail_lvl;
    logic pin_lvl;

    smr_sync #(
        .RESET_VAL (1'b0)
    ) u_fail_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (supply_fail_i),
        .level_o   (fail_lvl),
        .change_o  ()
    );

    smr_sync #(
        .RESET_VAL (1'b1)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (rst_pin_i),     // [RL6]
        .level_o   (pin_lvl),
        .change_o  ()
    );

    smr_state_t     state_q;
    smr_state_t     state_d;
    logic [CW-1:0]  cnt_q;
    logic [CW-1:0]  cnt_d;
    smr_pin_drive_t drv_q;
    smr_pin_drive_t drv_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SMR_ST_IDLE: begin
                cnt_d = '0;
                if (fail_lvl) begin
                    state_d = SMR_ST_FAIL;                       // [RL1] [RL3]
                end else if (cnt_q != '0) begin
                    // synced pin still shows our own pull, ignore it
                    cnt_d = cnt_q - CW'(1);                      // [RL8]
                end else if (!pin_lvl) begin
                    // press accepted only while no cycle runs
                    state_d = SMR_ST_PRESS;                      // [RL4]
                    cnt_d   = CW'(1);
                end
            end
            SMR_ST_FAIL: begin
                cnt_d = '0;
                if (!fail_lvl) begin
                    state_d = SMR_ST_STRETCH;                    // [RL2]
                end
            end
            SMR_ST_PRESS: begin
                if (fail_lvl) begin
                    state_d = SMR_ST_FAIL;
                end else if (pin_lvl) begin
                    // short glitch is ignored, full press stretches
                    state_d = (cnt_q >= CW'(PRESS_CNT)) ? SMR_ST_STRETCH : SMR_ST_IDLE; // [RL4] [RL5]
                    cnt_d   = '0;
                end else if (cnt_q < CW'(PRESS_CNT)) begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            SMR_ST_STRETCH: begin
                // pin reads low from own drive here; not looked at
                if (fail_lvl) begin
                    state_d = SMR_ST_FAIL;                       // [RL1]
                end else if (cnt_q == CW'(STRETCH_CNT - 1)) begin
                    state_d = SMR_ST_IDLE;                       // [RL2] [RL5] [RL8]
                    cnt_d   = CW'(SETTLE_CYCLES);
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            default: begin
                state_d = SMR_ST_FAIL;
                cnt_d   = '0;
            end
        endcase
        // open drain: only ever pull low; no pull during a press,
        // the button holds the pin low and its release must stay visible
        drv_d.out = 1'b0;
        drv_d.oe  = (state_d == SMR_ST_FAIL) || (state_d == SMR_ST_STRETCH); // [RL1] [RL5]
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // come out of reset asserting, as at power-up
            state_q <= SMR_ST_STRETCH;
            cnt_q   <= '0;
            drv_q   <= '{out: 1'b0, oe: 1'b1};
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            drv_q   <= drv_d;
        end
    end

    smr_trip_t trip_q;

    always_ff @(posedge sys_clk_i) begin
        trip_q <= TRIP_LEVEL;                                    // [RL7]
    end

    assign rst_pin_o           = drv_q.out;
    assign rst_pin_oe_o        = drv_q.oe;
    assign in_reset_o          = drv_q.oe;
    assign supply_trip_level_o = trip_q;
endmodule
`default_nettype wire

// file: testbench/smr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smr_checker
    import smr_pkg::*;
#(
    parameter smr_trip_t   TRIP  = SMR_TRIP_10PCT,
    parameter int unsigned PRESS = PRESS_MIN_CYCLES
) (
    input wire logic      sys_clk_i,
    input wire logic      rst_i,
    input wire logic      supply_fail_i,
    input wire logic      rst_pin_i,
    input wire logic      rst_pin_o,
    input wire logic      rst_pin_oe_o,
    input wire logic      in_reset_o,
    input wire smr_trip_t supply_trip_level_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_rsp; $rose(supply_fail_i) |-> ##[1:5] rst_pin_oe_o; endproperty
    a_rsp: assert property (p_rsp) else $error("slow");
    property p_hold; supply_fail_i [*6] |-> rst_pin_oe_o; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_str; $fell(supply_fail_i) |-> rst_pin_oe_o [*8]; endproperty
    a_str: assert property (p_str) else $error("short");
    property p_rel; $fell(rst_pin_oe_o) |-> !$past(supply_fail_i, 5); endproperty
    a_rel: assert property (p_rel) else $error("early");
    property p_od; rst_pin_o == 1'h0; endproperty
    a_od: assert property (p_od) else $error("drive");
    property p_mir; in_reset_o == rst_pin_oe_o; endproperty
    a_mir: assert property (p_mir) else $error("mirror");
    property p_trip; supply_trip_level_o == TRIP; endproperty
    a_trip: assert property (p_trip) else $error("trip");
    property p_btn;
        (PRESS <= 7 && !supply_fail_i && !rst_pin_oe_o && !rst_pin_i) [*8] ##1 rst_pin_i |-> ##[1:8] rst_pin_oe_o;
    endproperty
    a_btn: assert property (p_btn) else $error("press");
endmodule
bind smr_supervisor smr_checker #(.TRIP(TRIP_LEVEL), .PRESS(PRESS_CNT)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .supply_fail_i(supply_fail_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .in_reset_o(in_reset_o), .supply_trip_level_o(supply_trip_level_o));
`default_nettype wire

// file: testbench/smr_button.sv
`timescale 1ns/1ps
`default_nettype none
module smr_button (
    input  wire logic       clk_i,
    input  wire logic       oe_i,
    input  wire logic       go_i,
    input  wire logic [7:0] len_i,
    output logic            pin_o
);
    logic [7:0] cnt_q = 8'h00;
    always_ff @(posedge clk_i) cnt_q <= go_i ? len_i : cnt_q - 8'(cnt_q != 8'h00);
    // pull-up wins when nobody pulls
    assign pin_o = !(oe_i || cnt_q != 8'h00);
endmodule
`default_nettype wire

// file: testbench/supply_monitor_reset_stretcher_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_reset_stretcher_tb;
    import smr_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, fail = 1'h0, go = 1'h0, pin, oe, po, inr;
    logic [7:0]  len = 8'h00;
    smr_trip_t   lvl;
    int          fail_count = 0, comparisons = 0;
    int unsigned x = 73067;
    smr_supervisor #(.STRETCH_CNT(50), .PRESS_CNT(3), .TRIP_LEVEL(SMR_TRIP_20PCT)) DUT (.sys_clk_i(clk),
        .rst_i(rst), .supply_fail_i(fail), .rst_pin_i(pin), .rst_pin_o(po), .rst_pin_oe_o(oe),
        .in_reset_o(inr), .supply_trip_level_o(lvl));
    smr_button u_btn (.clk_i(clk), .oe_i(oe), .go_i(go), .len_i(len), .pin_o(pin));
    function automatic int unsigned rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // checks land after the edge's own updates
    task automatic chk(input logic e, input logic g, input string nm);
        #1;
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (1500) @(posedge clk);
        fail_count++;
        stop_test();
    end
    initial begin
        w(8);
        rst <= 1'h0;
        w(40);
        chk(1'h1, oe, "oe");
        chk(1'h1, lvl === SMR_TRIP_20PCT, "trip");
        w(20);
        fail <= 1'h1;
        chk(1'h0, oe, "oe");
        w(6);
        chk(1'h1, oe, "oe");
        w(10 + rnd() % 30);
        fail <= 1'h0;
        chk(1'h1, oe, "oe");
        w(20);
        go <= 1'h1;
        len <= 8'h05;
        w(1);
        go <= 1'h0;
        w(29);
        chk(1'h1, oe, "oe");
        w(10);
        chk(1'h0, oe, "oe");
        go <= 1'h1;
        len <= 8'(10 + rnd() % 20);
        w(1);
        go <= 1'h0;
        w(len / 2);
        chk(1'h0, pin, "pin");
        w(len - len / 2 + 6);
        chk(1'h1, oe, "oe");
        w(40);
        chk(1'h1, oe, "oe");
        w(15);
        chk(1'h0, oe, "oe");
        go <= 1'h1;
        len <= 8'h02;
        w(1);
        go <= 1'h0;
        w(30);
        chk(1'h0, oe, "oe");
        rst <= 1'h1;
        w(2);
        rst <= 1'h0;
        w(1);
        chk(1'h1, oe, "oe");
        w(60);
        chk(1'h0, oe, "oe");
        stop_test();
    end
endmodule
`default_nettype wire
